// *** verilog/irqmb_pkg.sv ***
package irqmb_pkg;

    // ************************************************************
    // register indices and byte addresses
    // ************************************************************
    localparam int ADDR_W = 18;
    localparam int GROUPS = 5;
    localparam logic [15:0] IDX_CLK_TICK_MASK = 16'hFFE6;
    localparam logic [15:0] IDX_STOPWATCH_MASK = 16'hFFE7;
    localparam logic [15:0] IDX_SERIAL_B_MASK = 16'hFFE8;
    localparam logic [15:0] IDX_DIALER_MASK = 16'hFFE9;
    localparam logic [15:0] IDX_FSK_DETECT_MASK = 16'hFFEA;
    // pending flags, one word per group, same layout as the masks
    localparam logic [15:0] IDX_PEND_BASE = 16'hFFF0;
    localparam logic [ADDR_W-1:0] ADDR_CLK_TICK_MASK = {IDX_CLK_TICK_MASK, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_FSK_DETECT_MASK = {IDX_FSK_DETECT_MASK, 2'h0};

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int CLK_TICK_32HZ_BIT = 0;
    localparam int CLK_TICK_8HZ_BIT = 1;
    localparam int STOPWATCH_10HZ_BIT = 0;
    localparam int STOPWATCH_1HZ_BIT = 1;
    localparam int SERIAL_B_RX_DONE_BIT = 0;
    localparam int SERIAL_B_TX_DONE_BIT = 1;
    localparam int SERIAL_B_ERROR_BIT = 2;
    localparam int DIALER_BIT = 0;
    localparam int CARRIER_DETECT_BIT = 0;
    localparam int RING_DETECT_BIT = 1;

    localparam logic [3:0] IMPL_CLK_TICK = 4'hF;
    localparam logic [3:0] IMPL_STOPWATCH = 4'h3;
    localparam logic [3:0] IMPL_SERIAL_B = 4'h7;
    localparam logic [3:0] IMPL_DIALER = 4'h1;
    // ring above carrier
    localparam logic [3:0] IMPL_FSK_DETECT = 4'h3;
    localparam logic [4*GROUPS-1:0] IMPL_ALL =
        {IMPL_FSK_DETECT, IMPL_DIALER, IMPL_SERIAL_B, IMPL_STOPWATCH, IMPL_CLK_TICK};

    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [3:0] PEND_RESET = 4'h0;

    // ************************************************************
    // bus handshake
    // ************************************************************
    typedef enum logic [1:0] {
        IRQMB_IDLE = 2'h0,
        IRQMB_ACK = 2'h1
    } irqmb_bus_state_t;

endpackage

// *** verilog/irqmb_slice.sv ***
`timescale 1ns/1ps
// one 4-bit group: mask bits plus sticky pending flags
module irqmb_slice #(
    parameter logic [3:0] IMPL = 4'hF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mask_we_i,
    input wire logic clr_we_i,
    input wire logic [3:0] wdata_i,
    input wire logic [3:0] req_i,
    output logic [3:0] mask_o,
    output logic [3:0] pend_o
);

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_bit
            if (IMPL[i]) begin : g_impl
                always_ff @(posedge clk_i or posedge rst_i) begin
                    if (rst_i) begin
                        mask_o[i] <= irqmb_pkg::MASK_RESET[i];
                    end else if (mask_we_i) begin
                        mask_o[i] <= wdata_i[i];
                    end
                end
                // a request in the clearing cycle wins, so no event is lost
                always_ff @(posedge clk_i or posedge rst_i) begin
                    if (rst_i) begin
                        pend_o[i] <= irqmb_pkg::PEND_RESET[i];
                    end else if (req_i[i]) begin
                        pend_o[i] <= 1'b1;
                    end else if (clr_we_i && wdata_i[i]) begin
                        pend_o[i] <= 1'b0;
                    end
                end
            end else begin : g_unused
                // no flop here, the position is tied low
                assign mask_o[i] = 1'b0;
                assign pend_o[i] = 1'b0;
            end
        end
    endgenerate

endmodule

// *** verilog/irqmb_top.sv ***
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module irqmb_top (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic [17:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic [3:0] CLK_TICK_REQ_I,
    input wire logic [1:0] STOPWATCH_REQ_I,
    input wire logic [2:0] SERIAL_B_REQ_I,
    input wire logic DIALER_REQ_I,
    input wire logic [1:0] FSK_DETECT_REQ_I,
    output logic IRQ_O
);

    // ************************************************************
    // declarations
    // ************************************************************
    localparam int G = irqmb_pkg::GROUPS;

    irqmb_pkg::irqmb_bus_state_t state;
    irqmb_pkg::irqmb_bus_state_t next_state;
    logic req_new;
    logic [15:0] word_idx;
    logic [15:0] mask_off;
    logic [15:0] pend_off;
    logic hit_mask;
    logic hit_pend;
    logic [2:0] grp;
    logic do_write;
    logic [31:0] next_readdata;
    logic [4*G-1:0] req_all;
    logic [4*G-1:0] mask_all;
    logic [4*G-1:0] pend_all;
    logic next_irq;

    // ************************************************************
    // address decode
    // ************************************************************
    // registers are consecutive indices, so one subtract decodes each bank, one for the masks and one for the pending words
    assign word_idx = AVS_ADDRESS_I[17:2];
    assign mask_off = word_idx - irqmb_pkg::IDX_CLK_TICK_MASK;
    assign pend_off = word_idx - irqmb_pkg::IDX_PEND_BASE;
    assign hit_mask = (AVS_ADDRESS_I[1:0] == 2'h0) && (mask_off < 16'(G));
    assign hit_pend = (AVS_ADDRESS_I[1:0] == 2'h0) && (pend_off < 16'(G));
    assign grp = hit_mask ? mask_off[2:0] : pend_off[2:0];
    assign req_new = (AVS_READ_I || AVS_WRITE_I) && (state == irqmb_pkg::IRQMB_IDLE);
    // the write lands on the edge where the master sees waitrequest low
    assign do_write = (state == irqmb_pkg::IRQMB_ACK) && AVS_WRITE_I && AVS_BYTEENABLE_I[0];

    // ************************************************************
    // bus handshake
    // ************************************************************
    always_comb begin
        next_state = irqmb_pkg::IRQMB_IDLE;
        unique case (state)
            irqmb_pkg::IRQMB_IDLE: begin
                next_state = req_new ? irqmb_pkg::IRQMB_ACK : irqmb_pkg::IRQMB_IDLE;
            end
            irqmb_pkg::IRQMB_ACK: begin
                next_state = irqmb_pkg::IRQMB_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state <= irqmb_pkg::IRQMB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            AVS_WAITREQUEST_O <= !(next_state == irqmb_pkg::IRQMB_ACK);
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    // unmapped words and unused bits read as zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (hit_mask) begin
            next_readdata[3:0] = mask_all[4*grp +: 4];
        end else if (hit_pend) begin
            next_readdata[3:0] = pend_all[4*grp +: 4];
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            AVS_READDATA_O <= 32'h0000_0000;
        end else if (req_new && AVS_READ_I) begin
            AVS_READDATA_O <= next_readdata;
        end
    end

    // ************************************************************
    // register bank
    // ************************************************************
    assign req_all = {2'h0, FSK_DETECT_REQ_I, 3'h0, DIALER_REQ_I, 1'b0, SERIAL_B_REQ_I,
                      2'h0, STOPWATCH_REQ_I, CLK_TICK_REQ_I};

    genvar g;
    generate
        for (g = 0; g < G; g++) begin : g_grp
            irqmb_slice #(
                .IMPL(irqmb_pkg::IMPL_ALL[4*g +: 4])
            ) u_slice (
                .clk_i(REF_CLK_I),
                .rst_i(RST_I),
                .mask_we_i(do_write && hit_mask && (mask_off == 16'(g))),
                .clr_we_i(do_write && hit_pend && (pend_off == 16'(g))),
                .wdata_i(AVS_WRITEDATA_I[3:0]),
                .req_i(req_all[4*g +: 4]),
                .mask_o(mask_all[4*g +: 4]),
                .pend_o(pend_all[4*g +: 4])
            );
        end
    endgenerate

    // ************************************************************
    // interrupt output
    // ************************************************************
    assign next_irq = |(pend_all & mask_all);

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= next_irq;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    logic wr_clk;
    logic wr_sw;
    logic wr_ser;
    logic wr_dial;
    logic wr_fsk;
    assign wr_clk = do_write && hit_mask && (mask_off == 16'h0);
    assign wr_sw = do_write && hit_mask && (mask_off == 16'h1);
    assign wr_ser = do_write && hit_mask && (mask_off == 16'h2);
    assign wr_dial = do_write && hit_mask && (mask_off == 16'h3);
    assign wr_fsk = do_write && hit_mask && (mask_off == 16'h4);

    a_clk_mask_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        wr_clk |=> mask_all[3:0] == $past(AVS_WRITEDATA_I[3:0]))
        else $error("clock timer mask not written");

    a_sw_mask_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        wr_sw |=> mask_all[7:4] == {2'h0, $past(AVS_WRITEDATA_I[1:0])})
        else $error("stopwatch mask wrong after write");

    a_serial_mask_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        wr_ser |=> mask_all[11:8] == {1'b0, $past(AVS_WRITEDATA_I[2:0])})
        else $error("serial mask wrong after write");

    a_dialer_mask_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        wr_dial |=> mask_all[15:12] == {3'h0, $past(AVS_WRITEDATA_I[0])})
        else $error("dialer mask wrong after write");

    a_ring_mask_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        wr_fsk |=> mask_all[16 + irqmb_pkg::RING_DETECT_BIT] == $past(AVS_WRITEDATA_I[1]))
        else $error("ring detect mask wrong after write");

    a_carrier_mask_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        wr_fsk |=> mask_all[16 + irqmb_pkg::CARRIER_DETECT_BIT] == $past(AVS_WRITEDATA_I[0]))
        else $error("carrier detect mask wrong after write");

    a_reset_masked: assert property (@(posedge REF_CLK_I)
        $fell(RST_I) |-> (mask_all == '0) && !IRQ_O)
        else $error("mask bits not clear after reset");

    a_unused_zero: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        ((mask_all | pend_all) & ~irqmb_pkg::IMPL_ALL) == '0 && AVS_READDATA_O[31:4] == '0)
        else $error("unused bit position not zero");

    a_irq_follows: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        ##1 IRQ_O == $past(|(pend_all & mask_all)))
        else $error("interrupt output does not follow masked pending");

    a_readback_clk: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (req_new && AVS_READ_I && AVS_ADDRESS_I == irqmb_pkg::ADDR_CLK_TICK_MASK)
        |=> !AVS_WAITREQUEST_O && AVS_READDATA_O[3:0] == $past(mask_all[3:0]))
        else $error("clock timer mask read back wrong");

    a_wait_one_cycle: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        req_new |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
        else $error("waitrequest not low for exactly one cycle");

    // helper for the set-wins check, unused positions dropped
    logic [4*G-1:0] req_impl;
    assign req_impl = req_all & irqmb_pkg::IMPL_ALL;

    a_pend_set_wins: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (req_impl != '0) |=> (pend_all & $past(req_impl)) == $past(req_impl))
        else $error("request did not set its pending bit");

    a_masked_quiet: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        ((pend_all & mask_all) == '0) |=> !IRQ_O)
        else $error("interrupt raised with no unmasked pending bit");

    a_be_ignored: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        ((state == irqmb_pkg::IRQMB_ACK) && AVS_WRITE_I && !AVS_BYTEENABLE_I[0])
        |=> $stable(mask_all))
        else $error("mask changed by write with byte lane 0 off");

    a_unmapped_zero: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (req_new && AVS_READ_I && !hit_mask && !hit_pend) |=> AVS_READDATA_O == '0)
        else $error("unmapped read not zero");

    c_fsk_write: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
        wr_fsk && AVS_WRITEDATA_I[1:0] == 2'h3);
    c_irq_raise: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
        $rose(IRQ_O));
    c_clear_race: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
        do_write && hit_pend && |req_all);
    c_read_pend: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
        req_new && AVS_READ_I && hit_pend);

endmodule

// *** verif/irqmb_core_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// core side: Avalon-MM master issuing one access at a time
// ************************************************************
module irqmb_core_model (
    input wire logic clk_i,
    input wire logic wait_i,
    input wire logic [31:0] rdata_i,
    output logic [17:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [31:0] wdata_o,
    output logic [3:0] be_o
);
    initial begin
        addr_o = 18'h00000;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 32'h00000000;
        be_o = 4'h0;
    end

    // request held until waitrequest is sampled low
    task automatic access(input logic is_wr, input logic [17:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        be_o <= be;
        rd_o <= !is_wr;
        wr_o <= is_wr;
        @(posedge clk_i);
        while (wait_i !== 1'b0) @(posedge clk_i);
        q = rdata_i;
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        // stale data never left on the bus
        wdata_o <= ~d;
        addr_o <= ~a;
    endtask
endmodule

// *** verif/irqmb_top_tb.sv ***
`timescale 1ns/1ps
module irqmb_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [17:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] be;
    logic waitreq;
    logic [11:0] req = 12'h000;
    logic irq;
    logic [31:0] q;
    logic [3:0] im;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    int off[5] = '{0, 4, 6, 9, 10};

    always #2.5 clk = ~clk;

    irqmb_top u_irqmb_top (.REF_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
        .CLK_TICK_REQ_I(req[3:0]), .STOPWATCH_REQ_I(req[5:4]), .SERIAL_B_REQ_I(req[8:6]),
        .DIALER_REQ_I(req[9]), .FSK_DETECT_REQ_I(req[11:10]), .IRQ_O(irq));

    irqmb_core_model u_irqmb_core_model (.clk_i(clk), .wait_i(waitreq), .rdata_i(rdata),
        .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .be_o(be));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [17:0] mask_a(int g);
        return irqmb_pkg::ADDR_CLK_TICK_MASK + 18'(4 * g);
    endfunction
    function automatic logic [17:0] pend_a(int g);
        return {irqmb_pkg::IDX_PEND_BASE, 2'h0} + 18'(4 * g);
    endfunction
    task automatic wr_reg(input logic [17:0] a, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] unused;
        u_irqmb_core_model.access(1'b1, a, d, b, unused);
    endtask
    task automatic rd_reg(input logic [17:0] a, output logic [31:0] d);
        u_irqmb_core_model.access(1'b0, a, 32'h00000000, 4'hF, d);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int g = 0; g < 5; g++) begin
            rd_reg(mask_a(g), q);
            check(q, 32'h00000000);
            im = irqmb_pkg::IMPL_ALL[4*g +: 4];
            for (int d = 0; d < 16; d++) begin
                wr_reg(mask_a(g), {28'hFFFFFFF, 4'(d)}, 4'hF);
                rd_reg(mask_a(g), q);
                check(q, {28'h0, 4'(d) & im});
            end
            wr_reg(mask_a(g), 32'h00000000, 4'hF);
        end
        rd_reg(mask_a(0) + 18'h00001, q);
        check(q, 32'h00000000);
        rd_reg(18'h00000, q);
        check(q, 32'h00000000);
        wr_reg(mask_a(0), 32'h0000000F, 4'h0);
        rd_reg(mask_a(0), q);
        check(q, 32'h00000000);
        for (int g = 0; g < 5; g++) begin
            im = irqmb_pkg::IMPL_ALL[4*g +: 4];
            for (int b = 0; b < 4; b++) begin
                if (im[b]) begin
                    wr_reg(mask_a(g), {28'h0, im & ~(4'h1 << b)}, 4'hF);
                    @(posedge clk);
                    req <= 12'h001 << (off[g] + b);
                    @(posedge clk);
                    req <= 12'h000;
                    repeat (4) @(posedge clk);
                    check({31'h0, irq}, 32'h00000000);
                    rd_reg(pend_a(g), q);
                    check(q, {28'h0, 4'h1 << b});
                    wr_reg(mask_a(g), {28'h0, 4'h1 << b}, 4'hF);
                    repeat (3) @(posedge clk);
                    check({31'h0, irq}, 32'h00000001);
                    wr_reg(pend_a(g), {28'h0, 4'h1 << b}, 4'hF);
                    repeat (3) @(posedge clk);
                    check({31'h0, irq}, 32'h00000000);
                    wr_reg(mask_a(g), 32'h00000000, 4'hF);
                end
            end
        end
        wr_reg(mask_a(2), 32'h00000007, 4'hF);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd_reg(mask_a(2), q);
        check(q, 32'h00000000);
        end_sim();
    end
endmodule
